// ### inc/ssp_spi_regs.vh
// Register map, field positions and timing counts of the SPI serial port
// Behaviour
// - Eight-bit words, shifted out and in together
// - All four clock polarity/phase combinations as master; as slave, clock-edge bit set needs a ninth leading edge per word
// - Three lines; slave select only in slave
// - Completed word copied to buffer unless slave overflows (buffer still full), irq flag set
// - Buffer write loads buffer and shift register
// - Shift register reachable only through buffer
// - Status upper two bits writable, rest read-only
// - Master samples at end or middle per bit
// - Clock-edge bit picks output edge, swapped by polarity
// - Buffer-full reads 1 when word is buffered
// - Mode field selects master rates or slave select
// - Polarity bit sets serial clock idle level
// - Write during transfer dropped, collision flag sticky
// - Reading buffer clears buffer-full
`ifndef SSP_SPI_REGS_VH
`define SSP_SPI_REGS_VH
// ==========================================
// Register offsets (byte addresses)
`define ADDR_STATUS 5'h00
`define ADDR_CONTROL 5'h04
`define ADDR_BUFFER 5'h08
`define ADDR_IRQ_STATUS 5'h0c
`define ADDR_IRQ_MASK 5'h10
// ==========================================
// Field positions
`define STAT_SMP 7
`define STAT_CKE 6
`define STAT_BF 0
`define CTRL_WRITE_COLLISION_FLAG 7
`define CTRL_RECEIVE_OVERFLOW_FLAG 6
`define CTRL_EN 5
`define CTRL_CKP 4
`define IRQ_DONE 0
`define IRQ_WRITE_COLLISION_FLAG 1
`define IRQ_OVF 2
// ==========================================
// Reset values and mode codes
`define STATUS_RESET 2'h0
`define CONTROL_RESET 6'h00
`define MODE_MASTER_DIV4 4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TMR2 4'h3
`define MODE_SLAVE_SS 4'h4
`define MODE_SLAVE_NOSS 4'h5
// ==========================================
// Half serial clock period in system clocks
`define HALF_DIV4 8'h02
`define HALF_DIV16 8'h08
`define HALF_DIV64 8'h20
`endif

// ### verilog/sync2.v
// Two-flip-flop synchroniser for one pin level
module sync2 (
  input wire clk_i,
  input wire rst_i,
  input wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;

  // First stage read only by the second
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end

  assign q_o = sync_reg;
endmodule // sync2

// ### verilog/ssp_spi.v
// SPI-mode synchronous serial port with Wishbone register access
`include "ssp_spi_regs.vh"

module ssp_spi (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output wire irq_o,
  input wire tmr2_i,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  input wire ss_n_i
);

  // ==========================================
  // Pin synchronisers
  wire sck_s;
  wire sdi_s;
  wire ss_n_s;
  wire tmr2_s;

  sync2 u_sck (.clk_i(clk_i), .rst_i(rst_i), .d_i(sck_i), .q_o(sck_s));
  sync2 u_sdi (.clk_i(clk_i), .rst_i(rst_i), .d_i(sdi_i), .q_o(sdi_s));
  sync2 u_ss (.clk_i(clk_i), .rst_i(rst_i), .d_i(ss_n_i), .q_o(ss_n_s));
  sync2 u_tmr (.clk_i(clk_i), .rst_i(rst_i), .d_i(tmr2_i), .q_o(tmr2_s));

  // ==========================================
  // Registers
  reg sample_phase_bit_reg;
  reg clock_edge_bit_reg;
  reg buffer_full_flag_reg;
  reg write_collision_flag_reg;
  reg receive_overflow_flag_reg;
  reg port_enable_bit_reg;
  reg clock_polarity_bit_reg;
  reg [3:0] port_mode_field_reg;
  reg [7:0] serial_buffer_reg;
  reg [7:0] serial_shift_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_mask_reg;

  // Transfer engine state
  reg busy_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] div_cnt_reg;
  reg [4:0] tick_cnt_reg;
  reg cap_d1_reg;
  reg cap_d2_reg;
  reg [7:0] rx_acc_reg;
  reg sck_prev_reg;
  reg tmr_prev_reg;
  reg sample_bit_reg;
  reg ss_active_prev_reg;

  wire is_master = (port_mode_field_reg[3:2] == 2'b00);
  wire is_slave = (port_mode_field_reg == `MODE_SLAVE_SS) ||
    (port_mode_field_reg == `MODE_SLAVE_NOSS);
  wire use_ss = (port_mode_field_reg == `MODE_SLAVE_SS);
  wire ss_active = !use_ss || !ss_n_s;

  // ==========================================
  // Wishbone decode
  wire bus_req = cyc_i && stb_i && !ack_o;
  wire wr_lo = bus_req && we_i && sel_i[0];
  wire rd_req = bus_req && !we_i;
  wire wr_status = wr_lo && (adr_i == 5'h00);
  wire wr_control = wr_lo && (adr_i == 5'h04);
  wire wr_buffer = wr_lo && (adr_i == 5'h08);
  wire wr_irq_status = wr_lo && (adr_i == 5'h0c);
  wire wr_irq_mask = wr_lo && (adr_i == 5'h10);
  wire rd_buffer = rd_req && (adr_i == 5'h08);

  // Master: buffer write while idle starts transfer
  wire load_ok = wr_buffer && !busy_reg && port_enable_bit_reg;
  wire collide = wr_buffer && busy_reg;

  // ==========================================
  // Master half-period tick
  reg [7:0] half_len;
  always @* begin
    case (port_mode_field_reg)
      `MODE_MASTER_DIV16: half_len = `HALF_DIV16;
      `MODE_MASTER_DIV64: half_len = `HALF_DIV64;
      default: half_len = `HALF_DIV4;
    endcase
  end

  // Timer output rising edge drives the /2 master rate
  wire tmr_tick = tmr2_s && !tmr_prev_reg;
  wire half_tick = (port_mode_field_reg == `MODE_MASTER_TMR2) ? tmr_tick :
    (div_cnt_reg == half_len - 8'h01);

  // ==========================================
  // Master tick schedule: 16 clock edges, one more for a late end sample
  wire [4:0] last_tick = (clock_edge_bit_reg && sample_phase_bit_reg) ? 5'h11 : 5'h10;
  wire tick_run = (tick_cnt_reg != last_tick);
  wire tick_ev = is_master && busy_reg && tick_run && half_tick;
  wire [4:0] tick_num = tick_cnt_reg + 5'h01;
  // Odd ticks are leading edges, even ticks trailing edges
  wire out_ev = tick_ev && (clock_edge_bit_reg ?
    (tick_num[0] && (tick_num != 5'h01) && (tick_num < 5'h10)) :
    (!tick_num[0] && (tick_num < 5'h10)));
  // Middle sample on the opposite edge, end sample on the next output edge
  wire cap_ev = tick_ev && (sample_phase_bit_reg ?
    (clock_edge_bit_reg ? (tick_num[0] && (tick_num != 5'h01)) : !tick_num[0]) :
    (clock_edge_bit_reg ? !tick_num[0] : tick_num[0]));
  // Done only once all eight bits landed and the clock is back at idle
  wire master_done = is_master && busy_reg && (bit_cnt_reg == 4'h8) && !tick_run;

  // ==========================================
  // Serial clock edges, normalised to leading and trailing
  wire sck_rise = sck_s && !sck_prev_reg;
  wire sck_fall = !sck_s && sck_prev_reg;
  // Leading edge leaves idle level; trailing returns to it
  wire slv_lead = clock_polarity_bit_reg ? sck_fall : sck_rise;
  wire slv_trail = clock_polarity_bit_reg ? sck_rise : sck_fall;
  // Edge bit set: output changes on the edge that leaves idle
  wire slv_shift = clock_edge_bit_reg ? slv_lead : slv_trail;
  wire slv_sample = clock_edge_bit_reg ? slv_trail : slv_lead;

  // ==========================================
  // Transfer engine: MSB first, shift out and in together
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      bit_cnt_reg <= 4'h0;
      div_cnt_reg <= 8'h00;
      tick_cnt_reg <= 5'h00;
      cap_d1_reg <= 1'b0;
      cap_d2_reg <= 1'b0;
      rx_acc_reg <= 8'h00;
      sck_prev_reg <= 1'b0;
      tmr_prev_reg <= 1'b0;
      sample_bit_reg <= 1'b0;
      ss_active_prev_reg <= 1'b0;
      serial_shift_reg <= 8'h00;
      sck_o <= 1'b0;
      sdo_o <= 1'b0;
    end else begin
      sck_prev_reg <= sck_s;
      tmr_prev_reg <= tmr2_s;
      ss_active_prev_reg <= ss_active;
      if (!port_enable_bit_reg) begin
        busy_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        div_cnt_reg <= 8'h00;
        tick_cnt_reg <= 5'h00;
        cap_d1_reg <= 1'b0;
        cap_d2_reg <= 1'b0;
        sck_o <= clock_polarity_bit_reg;
      end else if (is_master) begin
        if (load_ok) begin
          // Buffer write also loads shift register
          serial_shift_reg <= dat_i[7:0];
          busy_reg <= 1'b1;
          bit_cnt_reg <= 4'h0;
          div_cnt_reg <= 8'h00;
          tick_cnt_reg <= 5'h00;
          cap_d1_reg <= 1'b0;
          cap_d2_reg <= 1'b0;
          sdo_o <= dat_i[7];
        end else if (busy_reg) begin
          div_cnt_reg <= half_tick ? 8'h00 : div_cnt_reg + 8'h01;
          // The data pin lags two clocks in its synchroniser; the capture
          // strobe is delayed to match, so it sees the level at the edge
          cap_d1_reg <= cap_ev;
          cap_d2_reg <= cap_d1_reg;
          if (tick_ev) begin
            tick_cnt_reg <= tick_num;
            // The seventeenth tick only times the late sample
            if (tick_num <= 5'h10)
              sck_o <= !sck_o;
          end
          if (out_ev) begin
            // Transmit side moves on the output edge only
            serial_shift_reg <= {serial_shift_reg[6:0], 1'b0};
            sdo_o <= serial_shift_reg[6];
          end
          if (cap_d2_reg) begin
            // Receive side assembles MSB first
            rx_acc_reg <= {rx_acc_reg[6:0], sdi_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (master_done) begin
            // Received word ends up in the shift register as well
            busy_reg <= 1'b0;
            serial_shift_reg <= rx_acc_reg;
            sck_o <= clock_polarity_bit_reg;
          end
        end else begin
          sck_o <= clock_polarity_bit_reg;
        end
      end else if (is_slave) begin
        sck_o <= clock_polarity_bit_reg;
        // Load first: software preloads while the far master deselects us
        if (load_ok) begin
          serial_shift_reg <= dat_i[7:0];
          sdo_o <= dat_i[7];
        end else if (!ss_active) begin
          // Deselect aborts a partial word
          busy_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
        end else begin
          if (ss_active && !ss_active_prev_reg && !clock_edge_bit_reg)
            sdo_o <= serial_shift_reg[7];
          if (slv_sample) begin
            sample_bit_reg <= sdi_s;
            busy_reg <= 1'b1;
          end
          if (slv_shift && busy_reg) begin
            serial_shift_reg <= {serial_shift_reg[6:0], sample_bit_reg};
            sdo_o <= serial_shift_reg[6];
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == 4'h7) begin
              busy_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
            end
          end
        end
      end
    end
  end

  // Word completion: master after the last capture, slave on last shift
  wire slave_done = is_slave && ss_active && slv_shift && busy_reg &&
    (bit_cnt_reg == 4'h7) && !load_ok;
  wire word_done = port_enable_bit_reg && (master_done || slave_done);
  wire [7:0] rx_word = is_master ? rx_acc_reg :
    {serial_shift_reg[6:0], sample_bit_reg};
  wire overflow = slave_done && buffer_full_flag_reg;

  // Pin drive: clock out only as master, data out while enabled, in slave-select mode only while selected
  always @* begin
    sck_oe_o = port_enable_bit_reg && is_master;
    sdo_oe_o = port_enable_bit_reg && (is_master || ss_active);
  end

  // ==========================================
  // Register writes and flags; hardware set wins over clear
  always @(posedge clk_i) begin
    if (rst_i) begin
      sample_phase_bit_reg <= 1'b0;
      clock_edge_bit_reg <= 1'b0;
      buffer_full_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      receive_overflow_flag_reg <= 1'b0;
      port_enable_bit_reg <= 1'b0;
      clock_polarity_bit_reg <= 1'b0;
      port_mode_field_reg <= 4'h0;
      serial_buffer_reg <= 8'h00;
      irq_status_reg <= 3'h0;
      irq_mask_reg <= 3'h0;
    end else begin
      if (wr_status) begin
        sample_phase_bit_reg <= dat_i[`STAT_SMP];
        clock_edge_bit_reg <= dat_i[`STAT_CKE];
      end
      if (wr_control) begin
        port_enable_bit_reg <= dat_i[`CTRL_EN];
        clock_polarity_bit_reg <= dat_i[`CTRL_CKP];
        port_mode_field_reg <= dat_i[3:0];
      end
      // Software may only clear the sticky flags
      if (collide)
        write_collision_flag_reg <= 1'b1;
      else if (wr_control && !dat_i[`CTRL_WRITE_COLLISION_FLAG])
        write_collision_flag_reg <= 1'b0;
      if (overflow)
        receive_overflow_flag_reg <= 1'b1;
      else if (wr_control && !dat_i[`CTRL_RECEIVE_OVERFLOW_FLAG])
        receive_overflow_flag_reg <= 1'b0;
      // Buffer: write loads, completion copies unless overflowed
      if (load_ok)
        serial_buffer_reg <= dat_i[7:0];
      else if (word_done && !overflow)
        serial_buffer_reg <= rx_word;
      if (word_done && !overflow)
        buffer_full_flag_reg <= 1'b1;
      else if (rd_buffer)
        buffer_full_flag_reg <= 1'b0;
      // Interrupt status, write one to clear
      irq_status_reg <= (irq_status_reg & ~(wr_irq_status ? dat_i[2:0] : 3'h0)) |
        {overflow, collide, word_done};
      if (wr_irq_mask)
        irq_mask_reg <= dat_i[2:0];
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ==========================================
  // Read mux and single-wait-state ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= bus_req;
      if (rd_req) begin
        // Two-wire status bits read zero
        if (adr_i == 5'h00)
          dat_o <= {24'h000000, sample_phase_bit_reg, clock_edge_bit_reg,
            5'h00, buffer_full_flag_reg};
        else if (adr_i == 5'h04)
          dat_o <= {24'h000000, write_collision_flag_reg, receive_overflow_flag_reg,
            port_enable_bit_reg, clock_polarity_bit_reg, port_mode_field_reg};
        else if (adr_i == 5'h08)
          dat_o <= {24'h000000, serial_buffer_reg};
        else if (adr_i == 5'h0c)
          dat_o <= {29'h00000000, irq_status_reg};
        else if (adr_i == 5'h10)
          dat_o <= {29'h00000000, irq_mask_reg};
        else
          dat_o <= 32'h00000000;
      end
    end
  end
endmodule // ssp_spi

// ### verif/ssp_spi_asserts.sv
// Concurrent checks on the serial port's register bus and link pins
module ssp_spi_asserts (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [4:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o,
  input wire irq_o,
  input wire sck_o,
  input wire sck_oe_o,
  input wire sdo_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // Register bus
  chk_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack late");
  chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o)
    else $error("ack without request");
  chk_unmapped_zero: assert property (ack_o && !we_i &&
    !(adr_i inside {5'h00, 5'h04, 5'h08, 5'h0c, 5'h10}) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_status_unused: assert property (ack_o && !we_i && adr_i == 5'h00
    |-> dat_o[5:1] == 5'h00) else $error("two-wire bits set");
  // ==========================================
  // Link pins
  chk_reset_quiet: assert property ($fell(rst_i) |-> !irq_o && !sck_oe_o)
    else $error("active after reset");
  chk_sck_half: assert property (sck_oe_o && $changed(sck_o) |=> $stable(sck_o))
    else $error("sck half period short");
  // Data may move only around a clock edge or any bus acknowledge
  chk_sdo_edge: assert property (sck_oe_o && $past(sck_oe_o) && $changed(sdo_o)
    |-> $changed(sck_o) || $past(sck_o) != $past(sck_o, 2) || ack_o || $past(ack_o))
    else $error("sdo moved off edge");
  cover property (irq_o);
  cover property (sck_oe_o && $rose(sck_o));
  cover property (ack_o && we_i && adr_i == 5'h08);
endmodule // ssp_spi_asserts

// ### verif/spi_slave_model.sv
// Behavioural SPI slave standing on the master-mode link
module spi_slave_model (
  input wire sck_i,
  input wire ckp_i,
  input wire cke_i,
  input wire load_i,
  input wire [7:0] tx_i,
  input wire mosi_i,
  output logic miso_o,
  output logic [7:0] rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int n_out = 0;
  int k;
  initial rx_o = 8'h00;
  // New frame; config jumps of the idle level are forgotten here
  always @(posedge load_i) n_out = 0;
  // Output edge counts, the opposite edge captures MSB first
  always @(sck_i) begin
    if (sck_i === (ckp_i ^ cke_i)) n_out = n_out + 1;
    else rx_o = {rx_o[6:0], mosi_i};
  end
  // Released after the last bit: shows the inverse, not a held value
  always @* begin
    k = (n_out > cke_i) ? n_out - cke_i : 0;
    miso_o = (k > 7) ? ~tx_i[0] : tx_i[7 - k];
  end
endmodule // spi_slave_model

// ### verif/sync_serial_port_spi_mode_tb_top.sv
// Self-checking bench for the SPI serial port
`include "ssp_spi_regs.vh"
module sync_serial_port_spi_mode_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, tmr2 = 0, sck = 0, ss_n = 1;
  logic bsdi = 0, slv = 0, load = 0, clock_polarity_bit = 0, cke = 0;
  logic [4:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rd;
  logic [7:0] ptx = 0, got;
  wire [31:0] dat_o;
  wire ack_o, irq_o, sck_o, sck_oe_o, sdo_o, sdo_oe_o, miso;
  wire [7:0] prx;
  wire sdi = slv ? bsdi : miso;
  int fail_count = 0, n_compared = 0, tc = 0;
  ssp_spi dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
    .tmr2_i(tmr2), .sck_i(sck), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(ss_n));
  spi_slave_model part (.sck_i(sck_o), .ckp_i(clock_polarity_bit), .cke_i(cke), .load_i(load),
    .tx_i(ptx), .mosi_i(sdo_o), .miso_o(miso), .rx_o(prx));
  initial forever #10 clk_i = ~clk_i;
  // Timer output toggles every three clocks
  always @(posedge clk_i) begin
    tc <= (tc == 2) ? 0 : tc + 1;
    if (tc == 2) tmr2 <= ~tmr2;
  end
  // ==========================================
  // Shared tasks
  task conclude;
    if (fail_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic cycle, held until ack is sampled high
  task wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    for (i = 0; i < 40 && ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 40) begin
      fail_count++;
      conclude;
    end
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task rdchk(input logic [4:0] a, input logic [31:0] e, input string nm);
    wb(0, a, 32'h0);
    check(nm, rd, e);
  endtask
  task wirq;
    int i;
    for (i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge clk_i);
    if (i == 3000) begin
      fail_count++;
      conclude;
    end
  endtask
  // Bench as link master at 160 ns, data changed on the falling edge
  task frame(input logic [7:0] b);
    int i;
    ss_n <= 0;
    bsdi <= b[7];
    repeat (8) @(posedge clk_i);
    for (i = 0; i < 8; i++) begin
      sck <= 1;
      repeat (4) @(posedge clk_i);
      got = {got[6:0], sdo_o};
      sck <= 0;
      bsdi <= (i < 7) ? b[6 - i] : ~b[0];
      repeat (4) @(posedge clk_i);
    end
    ss_n <= 1;
    repeat (8) @(posedge clk_i);
  endtask
  // ==========================================
  // Scenarios
  task regs;
    rdchk(5'h00, 32'h0, "status reset");
    rdchk(5'h04, 32'h0, "control reset");
    wb(1, 5'h00, 32'hff);
    rdchk(5'h00, 32'hc0, "status read-only");
    wb(1, 5'h00, 32'h0);
    rdchk(5'h14, 32'h0, "unmapped");
  endtask
  task master(input logic [3:0] m, input logic p, e, s, input logic [7:0] tx, rx);
    clock_polarity_bit <= p;
    cke <= e;
    ptx <= rx;
    wb(1, 5'h04, {26'h1, p, m});
    wb(1, 5'h00, {24'h0, s, e, 6'h00});
    wb(1, 5'h10, 32'h1);
    load <= 1;
    @(posedge clk_i);
    load <= 0;
    wb(1, 5'h08, {24'h0, tx});
    wirq;
    check("sent byte", prx, tx);
    rdchk(5'h00, {s, e, 6'h01}, "bf set");
    rdchk(5'h0c, 32'h1, "done flag");
    rdchk(5'h08, rx, "rx byte");
    rdchk(5'h00, {s, e, 6'h00}, "bf clear");
    check("sck idle", sck_o, p);
    check("sck drive", sck_oe_o, 1'b1);
    wb(1, 5'h0c, 32'h1);
    @(negedge clk_i);
    check("irq cleared", irq_o, 1'b0);
  endtask
  task collide;
    load <= 1;
    @(posedge clk_i);
    load <= 0;
    wb(1, 5'h08, 32'h3c);
    wb(1, 5'h08, 32'hff);
    wb(0, 5'h04, 32'h0);
    check("write_collision_flag", rd[7], 1'b1);
    wirq;
    check("first kept", prx, 8'h3c);
    wb(1, 5'h04, {26'h1, clock_polarity_bit, `MODE_MASTER_TMR2});
    rdchk(5'h04, {26'h1, clock_polarity_bit, `MODE_MASTER_TMR2}, "write_collision_flag cleared");
    wb(0, 5'h08, 32'h0);
    wb(1, 5'h0c, 32'h7);
  endtask
  task slave;
    slv <= 1;
    wb(1, 5'h04, {26'h1, 1'b0, `MODE_SLAVE_SS});
    wb(1, 5'h00, 32'h0);
    wb(1, 5'h10, 32'h0);
    wb(1, 5'h08, 32'ha5);
    frame(8'h96);
    check("slave sdo", got, 8'ha5);
    rdchk(5'h00, 32'h1, "slave bf");
    check("masked irq", irq_o, 1'b0);
    check("slave sck in", sck_oe_o, 1'b0);
    frame(8'h0f);
    wb(0, 5'h04, 32'h0);
    check("overflow", rd[6], 1'b1);
    rdchk(5'h08, 32'h96, "old word kept");
    wb(0, 5'h0c, 32'h0);
    check("ovf irq", rd[2], 1'b1);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    regs;
    master(`MODE_MASTER_DIV4, 0, 0, 0, 8'h81, 8'h5a);
    master(`MODE_MASTER_DIV4, 0, 1, 0, 8'h42, 8'hc3);
    master(`MODE_MASTER_DIV4, 1, 0, 0, 8'h1e, 8'h01);
    master(`MODE_MASTER_DIV4, 1, 1, 0, 8'hf0, 8'h80);
    master(`MODE_MASTER_DIV16, 0, 0, 1, 8'h69, 8'h96);
    master(`MODE_MASTER_DIV64, 1, 1, 1, 8'ha5, 8'h3c);
    master(`MODE_MASTER_TMR2, 0, 1, 0, 8'h7e, 8'he7);
    collide;
    slave;
    conclude;
  end
endmodule // sync_serial_port_spi_mode_tb_top
bind ssp_spi ssp_spi_asserts chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .irq_o(irq_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_o(sdo_o));
